// File: cst_pkg.sv
// Package for the card strobe timing and SDRAM mode set block
// Assumes a 32-bit internal address bus and a 32-bit SDRAM bus
package cst_pkg;

  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam logic [31:0] CARD_TIMING_ADDR   = 32'hFF800018;
  localparam logic [31:0] MODE_AREA2_BASE    = 32'hFF900000;
  localparam logic [31:0] MODE_AREA3_BASE    = 32'hFF940000;
  localparam logic [31:0] MODE_WINDOW_MASK   = 32'hFFFFF000;
  localparam logic [15:0] CARD_TIMING_RESET  = 16'h0000;
  localparam logic [15:0] MODE_VALUE_MAX     = 16'h0FFC;
  localparam int          MODE_SHIFT         = 2;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int A5_EXTRA_LSB  = 14;
  localparam int A6_EXTRA_LSB  = 12;
  localparam int A5_ASSERT_LSB = 9;
  localparam int A6_ASSERT_LSB = 6;
  localparam int A5_HOLD_LSB   = 3;
  localparam int A6_HOLD_LSB   = 0;
  localparam int BURST_LSB     = 0;
  localparam int WRAP_BIT      = 3;
  localparam int LATENCY_LSB   = 4;

  // ****************************************************************
  // Wait encodings
  // ****************************************************************
  localparam logic [5:0] EXTRA_W1 = 6'h0F;
  localparam logic [5:0] EXTRA_W2 = 6'h1E;
  localparam logic [5:0] EXTRA_W3 = 6'h32;
  localparam logic [3:0] STEP_W4  = 4'h6;
  localparam logic [3:0] STEP_W5  = 4'h9;
  localparam logic [3:0] STEP_W6  = 4'hC;
  localparam logic [3:0] STEP_W7  = 4'hF;

  localparam logic [2:0] BURST_4   = 3'h2;
  localparam logic [2:0] BURST_8   = 3'h3;
  localparam logic [2:0] LATENCY_1 = 3'h1;
  localparam logic [2:0] LATENCY_3 = 3'h3;

  typedef struct packed {
    logic [5:0] extra;
    logic [3:0] setup;
    logic [3:0] hold;
  } cst_timing_t;

  typedef struct packed {
    logic        valid;
    logic        area3;
    logic [13:0] value;
  } cst_mode_cmd_t;

endpackage : cst_pkg

// File: cst_card_timing.sv
// Card strobe timing register and SDRAM mode register set issue
// Assumes a single-cycle register port and an external bus sequencer
//
// Chosen here: the plain strobed port.
`timescale 1ns/1ns

// Behaviour
// - 16-bit RW timing register, power-on clears
// - Strobe width from wait control two
// - Area5 extra waits 0/15/30/50
// - Area6 extra waits 0/15/30/50
// - Timing fields used only when mode bit zero
// - Area5 address-to-strobe delay steps
// - Area6 address-to-strobe delay steps
// - Area5 hold after strobe negation
// - Memory read hold counts from sampling
// - Area6 hold delay steps
// - Mode write stores nothing, issues set
// - Mode from address low bits, data ignored
// - Value shifted right two bits
// - Bases fixed, value up to 0FFC
// - Burst and latency codes; others reserved
// - Wrap type must be zero
module cst_card_timing #(
  parameter bit BURST8_OK = 1'b1
) (
  // Clock and reset
  input  wire logic                  I_CLK_SYS,
  input  wire logic                  I_RESETN,
  input  wire logic                  I_POWERON,
  // Register port
  input  wire logic [31:0]           I_ADDR,
  input  wire logic [31:0]           I_WDATA,
  input  wire logic                  I_WR,
  input  wire logic                  I_RD,
  output logic      [31:0]           O_RDATA,
  // External cycle context
  input  wire logic                  I_ACCESS_MODE_BIT,
  input  wire logic                  I_CYC_AREA5,
  input  wire logic                  I_CYC_AREA6,
  input  wire logic                  I_CYC_LOW_SPEED,
  input  wire logic                  I_CYC_MEM_READ,
  input  wire logic [3:0]            I_STROBE_WIDTH,
  input  wire logic                  I_BUS_BUSY,
  // Timing to the sequencer
  output cst_pkg::cst_timing_t       O_TIMING,
  output logic      [4:0]            O_STROBE_WIDTH,
  output logic                       O_HOLD_FROM_SAMPLE,
  // Mode register set to SDRAM
  output cst_pkg::cst_mode_cmd_t     O_MODE_CMD,
  output logic                       O_MODE_BAD
);

  // ****************************************************************
  // Wait decoding
  // ****************************************************************
  function automatic logic [3:0] step_waits(input logic [2:0] code);
    unique case (code)
      3'h4:    step_waits = cst_pkg::STEP_W4;
      3'h5:    step_waits = cst_pkg::STEP_W5;
      3'h6:    step_waits = cst_pkg::STEP_W6;
      3'h7:    step_waits = cst_pkg::STEP_W7;
      default: step_waits = {1'b0, code};
    endcase
  endfunction : step_waits

  function automatic logic [5:0] extra_waits(input logic [1:0] code);
    unique case (code)
      2'h0: extra_waits = 6'h00;
      2'h1: extra_waits = cst_pkg::EXTRA_W1;
      2'h2: extra_waits = cst_pkg::EXTRA_W2;
      2'h3: extra_waits = cst_pkg::EXTRA_W3;
    endcase
  endfunction : extra_waits

  // ****************************************************************
  // Timing register
  // ****************************************************************
  logic [15:0] card_strobe_timing_q;
  logic [15:0] card_strobe_timing_d;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  logic        hit_timing;

  assign hit_timing = (I_ADDR == cst_pkg::CARD_TIMING_ADDR);

  always_comb begin
    card_strobe_timing_d = card_strobe_timing_q;
    rdata_d              = 32'h00000000;
    if (I_WR && hit_timing) begin
      card_strobe_timing_d = I_WDATA[15:0];
    end
    if (I_RD && hit_timing) begin
      rdata_d = {16'h0000, card_strobe_timing_q};
    end
  end

  // Only power-on reset clears; manual reset keeps contents
  always_ff @(posedge I_CLK_SYS) begin
    if (!I_RESETN && I_POWERON) begin
      card_strobe_timing_q <= cst_pkg::CARD_TIMING_RESET;
    end else begin
      card_strobe_timing_q <= card_strobe_timing_d;
    end
    if (!I_RESETN) begin
      rdata_q <= 32'h00000000;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  assign O_RDATA = rdata_q;

  // ****************************************************************
  // Per-cycle timing selection
  // ****************************************************************
  cst_pkg::cst_timing_t timing_q;
  cst_pkg::cst_timing_t timing_d;
  logic [4:0]           width_q;
  logic [4:0]           width_d;
  logic                 from_sample_q;
  logic                 from_sample_d;
  logic [1:0]           ext_code;
  logic [2:0]           set_code;
  logic [2:0]           hld_code;

  always_comb begin
    ext_code      = 2'h0;
    set_code      = 3'h0;
    hld_code      = 3'h0;
    if (I_CYC_AREA5) begin
      ext_code = card_strobe_timing_q[cst_pkg::A5_EXTRA_LSB +: 2];
      set_code = card_strobe_timing_q[cst_pkg::A5_ASSERT_LSB +: 3];
      hld_code = card_strobe_timing_q[cst_pkg::A5_HOLD_LSB +: 3];
    end else if (I_CYC_AREA6) begin
      ext_code = card_strobe_timing_q[cst_pkg::A6_EXTRA_LSB +: 2];
      set_code = card_strobe_timing_q[cst_pkg::A6_ASSERT_LSB +: 3];
      hld_code = card_strobe_timing_q[cst_pkg::A6_HOLD_LSB +: 3];
    end
    timing_d.extra = 6'h00;
    timing_d.setup = 4'h0;
    timing_d.hold  = 4'h0;
    if (!I_ACCESS_MODE_BIT && (I_CYC_AREA5 || I_CYC_AREA6)) begin
      timing_d.extra = I_CYC_LOW_SPEED ? extra_waits(ext_code) : 6'h00;
      timing_d.setup = step_waits(set_code);
      timing_d.hold  = step_waits(hld_code);
    end
    width_d       = {1'b0, I_STROBE_WIDTH};
    from_sample_d = I_CYC_MEM_READ;
  end

  always_ff @(posedge I_CLK_SYS) begin
    if (!I_RESETN) begin
      timing_q      <= '0;
      width_q       <= 5'h00;
      from_sample_q <= 1'b0;
    end else begin
      timing_q      <= timing_d;
      width_q       <= width_d;
      from_sample_q <= from_sample_d;
    end
  end

  assign O_TIMING           = timing_q;
  assign O_STROBE_WIDTH     = width_q;
  assign O_HOLD_FROM_SAMPLE = from_sample_q;

  // ****************************************************************
  // Mode register set issue
  // ****************************************************************
  typedef enum logic [1:0] {MS_IDLE, MS_WAIT, MS_ISSUE} cst_mode_state_t;

  cst_mode_state_t state_q;
  cst_mode_state_t state_d;
  logic [13:0]     value_q;
  logic [13:0]     value_d;
  logic            area3_q;
  logic            area3_d;
  logic            bad_q;
  logic            bad_d;
  logic            hit_mode;
  logic [15:0]     enc;
  logic [13:0]     shifted;

  assign enc      = I_ADDR[15:0];
  assign shifted  = enc[15:cst_pkg::MODE_SHIFT];
  assign hit_mode = I_WR && (enc <= cst_pkg::MODE_VALUE_MAX) &&
                    (((I_ADDR & cst_pkg::MODE_WINDOW_MASK) == cst_pkg::MODE_AREA2_BASE) ||
                     ((I_ADDR & cst_pkg::MODE_WINDOW_MASK) == cst_pkg::MODE_AREA3_BASE));

  always_comb begin
    logic [2:0] burst_code;
    logic [2:0] lat;
    burst_code = shifted[cst_pkg::BURST_LSB +: 3];
    lat        = shifted[cst_pkg::LATENCY_LSB +: 3];
    state_d = state_q;
    value_d = value_q;
    area3_d = area3_q;
    bad_d   = bad_q;
    unique case (state_q)
      MS_IDLE: begin
        if (hit_mode) begin
          value_d = shifted;
          area3_d = (I_ADDR & cst_pkg::MODE_WINDOW_MASK) == cst_pkg::MODE_AREA3_BASE;
          bad_d   = !((burst_code == cst_pkg::BURST_4) ||
                      (BURST8_OK && burst_code == cst_pkg::BURST_8)) ||
                    (lat < cst_pkg::LATENCY_1) || (lat > cst_pkg::LATENCY_3) ||
                    shifted[cst_pkg::WRAP_BIT];
          state_d = MS_WAIT;
        end
      end
      MS_WAIT: begin
        if (!I_BUS_BUSY) begin
          state_d = MS_ISSUE;
        end
      end
      MS_ISSUE: begin
        state_d = MS_IDLE;
      end
      default: begin
        state_d = MS_IDLE;
      end
    endcase
  end

  always_ff @(posedge I_CLK_SYS) begin
    if (!I_RESETN) begin
      state_q <= MS_IDLE;
      value_q <= 14'h0000;
      area3_q <= 1'b0;
      bad_q   <= 1'b0;
    end else begin
      state_q <= state_d;
      value_q <= value_d;
      area3_q <= area3_d;
      bad_q   <= bad_d;
    end
  end

  assign O_MODE_CMD.valid = (state_q == MS_ISSUE);
  assign O_MODE_CMD.area3 = area3_q;
  assign O_MODE_CMD.value = value_q;
  assign O_MODE_BAD       = bad_q;

  // ****************************************************************
  // Checks
  // ****************************************************************
  a_mode_bit_gate: assert property (@(posedge I_CLK_SYS) disable iff (!I_RESETN)
    I_ACCESS_MODE_BIT |=> (O_TIMING == '0))
    else $error("timing fields used while access mode bit set");

  a_area5_extra: assert property (@(posedge I_CLK_SYS) disable iff (!I_RESETN)
    (I_CYC_AREA5 && !I_ACCESS_MODE_BIT && I_CYC_LOW_SPEED &&
     card_strobe_timing_q[15:14] == 2'h3) |=> (O_TIMING.extra == 6'h32))
    else $error("area5 extra wait wrong");

  a_area6_extra: assert property (@(posedge I_CLK_SYS) disable iff (!I_RESETN)
    (!I_CYC_AREA5 && I_CYC_AREA6 && !I_ACCESS_MODE_BIT && I_CYC_LOW_SPEED &&
     card_strobe_timing_q[13:12] == 2'h1) |=> (O_TIMING.extra == 6'h0F))
    else $error("area6 extra wait wrong");

  a_area5_setup: assert property (@(posedge I_CLK_SYS) disable iff (!I_RESETN)
    (I_CYC_AREA5 && !I_ACCESS_MODE_BIT && card_strobe_timing_q[11:9] == 3'h5)
    |=> (O_TIMING.setup == 4'h9))
    else $error("area5 setup delay wrong");

  a_area6_setup: assert property (@(posedge I_CLK_SYS) disable iff (!I_RESETN)
    (!I_CYC_AREA5 && I_CYC_AREA6 && !I_ACCESS_MODE_BIT &&
     card_strobe_timing_q[8:6] == 3'h7) |=> (O_TIMING.setup == 4'hF))
    else $error("area6 setup delay wrong");

  a_area5_hold: assert property (@(posedge I_CLK_SYS) disable iff (!I_RESETN)
    (I_CYC_AREA5 && !I_ACCESS_MODE_BIT && card_strobe_timing_q[5:3] == 3'h6)
    |=> (O_TIMING.hold == 4'hC))
    else $error("area5 hold delay wrong");

  a_area6_hold: assert property (@(posedge I_CLK_SYS) disable iff (!I_RESETN)
    (!I_CYC_AREA5 && I_CYC_AREA6 && !I_ACCESS_MODE_BIT &&
     card_strobe_timing_q[2:0] == 3'h3) |=> (O_TIMING.hold == 4'h3))
    else $error("area6 hold delay wrong");

  a_no_area_zero: assert property (@(posedge I_CLK_SYS) disable iff (!I_RESETN)
    (!I_CYC_AREA5 && !I_CYC_AREA6) |=> (O_TIMING == '0))
    else $error("timing applied outside card areas");

  a_width_pass: assert property (@(posedge I_CLK_SYS) disable iff (!I_RESETN)
    1'b1 |=> (O_STROBE_WIDTH == {1'b0, $past(I_STROBE_WIDTH)}))
    else $error("strobe width not from wait control");

  a_mode_issue: assert property (@(posedge I_CLK_SYS) disable iff (!I_RESETN)
    (state_q == MS_IDLE && hit_mode) ##1 !I_BUS_BUSY |=> O_MODE_CMD.valid ##1 !O_MODE_CMD.valid)
    else $error("mode set not issued once after bus idle");

  a_mode_value: assert property (@(posedge I_CLK_SYS) disable iff (!I_RESETN)
    (state_q == MS_IDLE && hit_mode) |=> (O_MODE_CMD.value == $past(I_ADDR[15:2])))
    else $error("mode value not from shifted address");

  a_busy_holds: assert property (@(posedge I_CLK_SYS) disable iff (!I_RESETN)
    I_BUS_BUSY && state_q == MS_WAIT |=> !O_MODE_CMD.valid)
    else $error("mode set issued during bus cycle");

  c_mode_area2: cover property (@(posedge I_CLK_SYS) O_MODE_CMD.valid && !O_MODE_CMD.area3);
  c_mode_area3: cover property (@(posedge I_CLK_SYS) O_MODE_CMD.valid && O_MODE_CMD.area3);
  c_low_speed5: cover property (@(posedge I_CLK_SYS) O_TIMING.extra == 6'h32);
  c_reg_read:   cover property (@(posedge I_CLK_SYS) I_RD && hit_timing);

endmodule : cst_card_timing

// File: cst_sdram_model.sv
// Partner model: SDRAM side, keeps the bus busy on request, counts mode sets
// Assumes a stall starts with a bench write while i_len is not zero
`timescale 1ns/1ns
module cst_sdram_model (
  input  wire logic                   clk,
  input  wire logic                   rst_n,
  input  wire logic                   i_start,
  input  wire logic [7:0]             i_len,
  input  wire cst_pkg::cst_mode_cmd_t i_cmd,
  output logic                        o_busy,
  output logic [7:0]                  o_sets,
  output logic [7:0]                  o_bad
);
  logic [7:0] cnt_q;
  logic       busy_q;
  assign o_busy = cnt_q != 8'h00;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cnt_q <= 8'h00;
      busy_q <= 1'b0;
      o_sets <= 8'h00;
      o_bad <= 8'h00;
    end else begin
      busy_q <= o_busy;
      if (i_start && i_len != 8'h00)
        cnt_q <= i_len;
      else if (o_busy)
        cnt_q <= cnt_q - 8'h01;
      if (i_cmd.valid)
        o_sets <= o_sets + 8'h01;
      if (i_cmd.valid && busy_q)
        o_bad <= o_bad + 8'h01;
    end
  end
endmodule : cst_sdram_model

// File: pcmcia_timing_sdram_mode_set_tb.sv
// Self-checking bench: register port, timing path and mode sets
// Assumes the partner model drives the bus busy flag
`timescale 1ns/1ns
module pcmcia_timing_sdram_mode_set_tb;
  logic clk = 1'b0, rst_n = 1'b0, po = 1'b1, wr = 1'b0, rd = 1'b0;
  logic mb = 1'b0, a5 = 1'b0, a6 = 1'b0, ls = 1'b0, mr = 1'b0;
  logic tchk = 1'b0, rd_s = 1'b0, t_s = 1'b0, busy, mbad, hfs;
  logic [31:0] addr = 32'h0, wdata = 32'h0, rdata, d;
  logic [3:0]  sw = 4'h0;
  logic [4:0]  osw;
  logic [7:0]  len = 8'h00, sets, bad;
  logic [15:0] cur = 16'h0000;
  logic [2:0]  k, lt, bs;
  cst_pkg::cst_timing_t   tim;
  cst_pkg::cst_mode_cmd_t cmd;
  logic [31:0] q_rd[$];
  logic [19:0] q_tim[$];
  logic [15:0] q_md[$];
  integer seed = 32'hAD49;
  int n_fail = 0, checks = 0, i, c;
  localparam logic [31:0] TA = cst_pkg::CARD_TIMING_ADDR;

  always #2 clk = ~clk;

  cst_card_timing dut (.I_CLK_SYS(clk), .I_RESETN(rst_n), .I_POWERON(po), .I_ADDR(addr),
    .I_WDATA(wdata), .I_WR(wr), .I_RD(rd), .O_RDATA(rdata), .I_ACCESS_MODE_BIT(mb),
    .I_CYC_AREA5(a5), .I_CYC_AREA6(a6), .I_CYC_LOW_SPEED(ls), .I_CYC_MEM_READ(mr),
    .I_STROBE_WIDTH(sw), .I_BUS_BUSY(busy), .O_TIMING(tim), .O_STROBE_WIDTH(osw),
    .O_HOLD_FROM_SAMPLE(hfs), .O_MODE_CMD(cmd), .O_MODE_BAD(mbad));
  cst_sdram_model sdram (.clk(clk), .rst_n(rst_n), .i_start(wr), .i_len(len), .i_cmd(cmd),
    .o_busy(busy), .o_sets(sets), .o_bad(bad));

  // ****************************************************************
  // Helpers
  // ****************************************************************
  task check(input logic [31:0] s, input logic [31:0] e);
    checks++;
    if (s !== e) begin
      n_fail++;
      $display("wrong value at %0t: seen %h expected %h", $time, s, e);
    end
  endtask : check

  task report_and_stop;
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : report_and_stop

  task bus(input logic w, input logic r, input logic [31:0] a, input logic [31:0] x);
    @(posedge clk);
    wr <= w;
    rd <= r;
    addr <= a;
    wdata <= x;
    tchk <= 1'b0;
  endtask : bus

  task rdchk(input logic [31:0] a, input logic [31:0] e);
    q_rd.push_back(e);
    bus(1'b0, 1'b1, a, $random(seed));
  endtask : rdchk

  task rst(input logic p);
    bus(1'b0, 1'b0, 32'h0, 32'h0);
    @(posedge clk);
    rst_n <= 1'b0;
    po <= p;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
  endtask : rst

  function logic [3:0] step(input logic [2:0] v);
    return (v < 3'h4) ? {1'b0, v} : 4'h6 + 4'h3 * (v - 3'h4);
  endfunction : step

  function logic [5:0] ext(input logic [1:0] v);
    return (v == 2'h0) ? 6'h00 : (v == 2'h1) ? 6'h0F : (v == 2'h2) ? 6'h1E : 6'h32;
  endfunction : ext

  task probe(input logic m, input logic x5, input logic x6, input logic l, input logic r);
    logic [5:0] e;
    logic [3:0] s, h, w;
    d = $random(seed);
    w = m ? 4'h0 : d[3:0];
    e = (!l || m) ? 6'h00 : x5 ? ext(cur[15:14]) : ext(cur[13:12]);
    s = m ? 4'h0 : x5 ? step(cur[11:9]) : step(cur[8:6]);
    h = m ? 4'h0 : x5 ? step(cur[5:3]) : step(cur[2:0]);
    q_tim.push_back({e, s, h, 1'b0, w, r & !m});
    @(posedge clk);
    wr <= 1'b0;
    rd <= 1'b0;
    tchk <= 1'b1;
    {mb, a5, a6, ls, mr, sw} <= {m, x5, x6, l, r & !m, w};
  endtask : probe

  task mode(input logic a3, input logic [15:0] off, input logic [7:0] l);
    logic [13:0] v;
    logic        bd;
    logic [31:0] a;
    v = off[15:2];
    bd = !(v[2:0] inside {3'h2, 3'h3}) || v[3] || !(v[6:4] inside {3'h1, 3'h2, 3'h3});
    q_md.push_back({a3, v, bd});
    a = (a3 ? cst_pkg::MODE_AREA3_BASE : cst_pkg::MODE_AREA2_BASE) + {16'h0000, off};
    len <= l;
    bus(1'b1, 1'b0, a, $random(seed));
    if (l != 8'h00)
      bus(1'b1, 1'b0, cst_pkg::MODE_AREA2_BASE + 32'h88, $random(seed));
    bus(1'b0, 1'b0, 32'h0, 32'h0);
    for (c = 0; c < 60 && q_md.size() != 0; c++) @(posedge clk);
    check(q_md.size(), 32'h00000000);
  endtask : mode

  // ****************************************************************
  // Result monitor
  // ****************************************************************
  always @(posedge clk) begin
    rd_s <= rd;
    t_s <= tchk;
  end
  always @(negedge clk) begin
    if (rd_s)
      check(rdata, q_rd.pop_front());
    if (t_s)
      check({12'h000, tim, osw, hfs}, {12'h000, q_tim.pop_front()});
    if (cmd.valid)
      check({16'h0, cmd.area3, cmd.value, mbad}, {16'h0, q_md.pop_front()});
  end

  // ****************************************************************
  // Sequence
  // ****************************************************************
  initial begin
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    rdchk(TA, {16'h0000, cst_pkg::CARD_TIMING_RESET});
    rdchk(32'hFF80001C, 32'h0);
    d = $random(seed);
    cur = d[15:0];
    bus(1'b1, 1'b0, TA, d);
    rdchk(TA, {16'h0000, cur});
    bus(1'b1, 1'b0, 32'hFF80001C, $random(seed));
    rdchk(TA, {16'h0000, cur});
    rst(1'b0);
    rdchk(TA, {16'h0000, cur});
    rst(1'b1);
    cur = 16'h0000;
    rdchk(TA, 32'h0);
    for (i = 0; i < 8; i++) begin
      k = i[2:0];
      cur = {k[1:0], k[2:1], k, k + 3'h1, k + 3'h2, k + 3'h3};
      bus(1'b1, 1'b0, TA, {16'h0000, cur});
      probe(1'b0, 1'b1, 1'b0, 1'b1, k[0]);
      probe(1'b0, 1'b0, 1'b1, 1'b1, k[1]);
      probe(1'b0, 1'b0, 1'b1, 1'b0, k[2]);
      probe(1'b0, 1'b1, 1'b1, 1'b1, 1'b1);
      probe(1'b1, 1'b1, 1'b0, 1'b1, 1'b1);
    end
    // Mode sets after timing setup, before any SDRAM traffic
    for (i = 0; i < 12; i++) begin
      lt = 3'h1 + 3'(i >> 2);
      bs = 3'h2 + {2'b00, i[1]};
      mode(i[0], {7'h00, lt, 1'b0, bs, 2'b00}, 8'h00);
    end
    mode(1'b0, cst_pkg::MODE_VALUE_MAX, 8'h00);
    d = $random(seed);
    mode(1'b1, d[15:0] & 16'h0FFC, 8'h14);
    bus(1'b1, 1'b0, cst_pkg::MODE_AREA2_BASE + 32'h1000, $random(seed));
    bus(1'b0, 1'b0, 32'h0, 32'h0);
    repeat (8) @(posedge clk);
    check({24'h0, sets}, 32'h0000000E);
    check(q_rd.size() + q_tim.size(), 32'h00000000);
    check({24'h0, bad}, 32'h0);
    report_and_stop();
  end

  initial begin
    #80000;
    n_fail++;
    report_and_stop();
  end
endmodule : pcmcia_timing_sdram_mode_set_tb
